// ---- design/video_glue_pkg.sv ----
// Constants shared by the color plane glue logic
package video_glue_pkg;

   // CPU port map
   localparam logic [7:0] BOARD_ID_ADDR   = 8'h2C;
   localparam logic [7:0] PLANE_SEL_ADDR  = 8'h2D;
   localparam logic [7:0] CTL_LO_A_FIRST  = 8'h2C;
   localparam logic [7:0] CTL_LO_A_LAST   = 8'h2D;
   localparam logic [7:0] CTL_HI_A_FIRST  = 8'h38;
   localparam logic [7:0] CTL_HI_A_LAST   = 8'h3B;

   // Plane select codes and bit positions
   localparam logic [7:0] SEL_BLUE        = 8'h01;
   localparam logic [7:0] SEL_GREEN       = 8'h02;
   localparam logic [7:0] SEL_RED         = 8'h04;
   localparam int         BIT_BLUE        = 0;
   localparam int         BIT_GREEN       = 1;
   localparam int         BIT_RED         = 2;
   localparam logic [7:0] PLANE_SEL_RESET = 8'h00;
   localparam int         PLANES          = 3;

   // Plane memory and frame geometry
   localparam int         WORD_BITS       = 16;
   localparam int         PLANE_WORDS     = 16384;
   localparam int         H_PIXELS        = 640;
   localparam int         V_LINES         = 400;

   // Dot clock timing; one ref_clk cycle is one dot
   localparam int         DIV_STAGES      = 3;
   localparam int         CTL_DIV         = 2 ** DIV_STAGES;
   localparam int         QUARTER_DOTS    = CTL_DIV / 4;
   localparam logic [3:0] LOAD_PHASE      = 4'hF;

   // Phases of the controller clock counter (0 = rising edge)
   localparam logic [2:0] PH_CTL_LAST     = 3'h7;
   localparam logic [2:0] PH_ROW          = 3'h1;
   localparam logic [2:0] PH_MUX          = 3'h2;
   localparam logic [2:0] PH_COL          = 3'h3;
   localparam logic [2:0] PH_ALS_END      = 3'h1;

endpackage

// ---- design/pixel_shifter.sv ----
// Parallel-load, serial-out shift register for one color plane
`timescale 1ns/1ps
module pixel_shifter
   import video_glue_pkg::*;
#(
   parameter int WORD_W = WORD_BITS
) (
   input  wire logic              ref_clk, // Dot clock
   input  wire logic              rstn,    // Async reset, active low
   input  wire logic              load,    // Parallel load pulse
   input  wire logic [WORD_W-1:0] pdata,   // Plane word from bus
   output logic                   sout     // Serial pixel, MSB first
);

   typedef struct packed {
      logic [WORD_W-1:0] sh;
   } shift_state_t;

   shift_state_t st_reg;
   shift_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (load) begin
         st_next.sh = pdata;
      end else begin
         st_next.sh = {st_reg.sh[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sout = st_reg.sh[WORD_W-1];

endmodule

// ---- design/color_video_plane_glue.sv ----
// Glue logic around the graphics controller on the color monitor board
//
// Overview of operation
// - Plane-select value 01H picks blue, 02H green, 04H red onto the bus.
// - Each color plane holds 16-bit words, 16K words deep.
// - Controller clock is the oscillator divided by eight through three halvers.
// - Undivided oscillator is the dot clock; one pixel per cycle.
// - Row strobe is delayed one quarter controller clock.
// - Column strobe follows the row strobe a further quarter clock later.
// - Same timing logic makes the multiplexer select and address latch strobe.
// - Read strobe low opens only the selected plane's output buffer.
// - Buffer enable A follows data bus bit three; plane buffers do not use it.
// - Write strobe asserts 2.25 controller clocks after read strobe trails.
// - Write delay is two controller clock stages plus a quarter stage.
// - Display-cycle plane words are taken from the shared bus.
// - A parallel load pulse every 16 dots loads each shift register.
// - Serial pixels from all planes are re-registered on the dot clock.
// - Every color is ANDed with not-blanking.
// - Red, green and blue are separate active-high NRZ outputs.
// - Sync outputs are active low by default.
// - Sync passes a register with static per-monitor polarity option.
// - Frame is 640 by 400 pixels, eight colors from three planes.
// - Port 2CH returns a board identification value.
// - Addresses 2CH-2DH and 38H-3BH are decoded for the controller.
`timescale 1ns/1ps
module color_video_plane_glue
   import video_glue_pkg::*;
#(
   parameter logic [7:0] BOARD_ID = 8'h5A, // Arbitrary identification value
   parameter int         WORD_W   = WORD_BITS
) (
   input  wire logic                    ref_clk,              // Oscillator, dot clock
   input  wire logic                    rstn,                 // Async reset, active low
   input  wire logic [7:0]              io_addr,              // CPU I/O address
   input  wire logic                    io_wr,                // CPU write strobe
   input  wire logic                    io_rd,                // CPU read strobe
   input  wire logic [7:0]              io_wdata,             // CPU write data
   output logic [7:0]                   io_rdata,             // CPU read data
   output logic                         io_rdata_valid,       // Read data valid
   output logic                         ctl_select,           // Controller channel hit
   output logic                         controller_clock,     // Divided clock
   input  wire logic                    ctl_row_strobe_n,     // Row strobe from controller
   input  wire logic                    read_direction_strobe_n, // Controller read strobe
   input  wire logic                    data_bus_bit_three,   // Bus bit 3
   input  wire logic                    blank,                // Blanking, high active
   input  wire logic                    ctl_hsync,            // Horizontal sync in
   input  wire logic                    ctl_vsync,            // Vertical sync in
   input  wire logic                    hsync_invert,         // Static polarity option
   input  wire logic                    vsync_invert,         // Static polarity option
   input  wire logic [PLANES*WORD_W-1:0] plane_words,         // Plane words on bus
   output logic                         row_strobe_n,         // Plane row strobe
   output logic                         column_strobe_n,      // Plane column strobe
   output logic                         mux_select,           // High = column address
   output logic                         address_latch_strobe, // Address latch enable
   output logic                         plane_we_n,           // Plane write strobe
   output logic [2:0]                   plane_sel,            // Plane to bus select
   output logic                         buffer_enable_a_n,    // Buffer enable, bit 3
   output logic [2:0]                   buffer_enable_b_n,    // Buffer enable per plane
   output logic                         shift_load,           // Parallel load pulse
   output logic                         red,                  // Red pixel
   output logic                         green,                // Green pixel
   output logic                         blue,                 // Blue pixel
   output logic                         hsync_n,              // Horizontal sync out
   output logic                         vsync_n               // Vertical sync out
);

   typedef struct packed {
      logic [2:0] div;
      logic       ctl_clk;
      logic       row_n;
      logic       col_n;
      logic       mux;
      logic       als;
      logic       d1;
      logic       d2;
      logic       d3;
      logic       we_n;
      logic [7:0] sel;
      logic [7:0] rdata;
      logic       rvalid;
      logic       csel;
      logic       buf_a_n;
      logic [2:0] buf_b_n;
      logic [3:0] dot;
      logic       load;
      logic [2:0] rgb;
      logic       hs_n;
      logic       vs_n;
   } glue_state_t;

   glue_state_t s_reg;
   glue_state_t s_next;
   logic [2:0]  serial;

   ////////////////////////////////////////////////////////////
   // Pixel shift registers, one per plane

   generate
      for (genvar p = 0; p < PLANES; p++) begin : g_plane
         pixel_shifter #(
            .WORD_W (WORD_W)
         ) u_shift (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .load    (s_reg.load),
            .pdata   (plane_words[p*WORD_W +: WORD_W]),
            .sout    (serial[p])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;

      s_next.div     = s_reg.div + 3'h1;
      s_next.ctl_clk = ~s_next.div[DIV_STAGES-1];

      if (s_reg.div == PH_ROW) begin
         s_next.row_n = ctl_row_strobe_n;
      end
      if (s_reg.div == PH_MUX) begin
         s_next.mux = ~s_reg.row_n;
      end
      if (s_reg.div == PH_COL) begin
         s_next.col_n = s_reg.row_n;
      end
      s_next.als = (s_reg.div == PH_CTL_LAST) || (s_reg.div < PH_ALS_END);

      if (s_reg.div == PH_CTL_LAST) begin
         s_next.d1 = read_direction_strobe_n;
         s_next.d2 = s_reg.d1;
         s_next.d3 = s_reg.d2;
      end
      if (s_reg.div == PH_ROW) begin
         s_next.we_n = ~(s_reg.d2 & ~s_reg.d3);
      end

      s_next.csel = (io_rd || io_wr) &&
                    (((io_addr >= CTL_LO_A_FIRST) && (io_addr <= CTL_LO_A_LAST)) ||
                     ((io_addr >= CTL_HI_A_FIRST) && (io_addr <= CTL_HI_A_LAST)));

      if (io_wr && (io_addr == PLANE_SEL_ADDR)) begin
         s_next.sel = io_wdata;
      end

      s_next.rvalid = 1'b0;
      s_next.rdata  = 8'h00;
      if (io_rd) begin
         if (io_addr == BOARD_ID_ADDR) begin
            s_next.rdata  = BOARD_ID;
            s_next.rvalid = 1'b1;
         end else if (io_addr == PLANE_SEL_ADDR) begin
            s_next.rdata  = s_reg.sel;
            s_next.rvalid = 1'b1;
         end
      end

      // buffer gated by bus bit three
      s_next.buf_a_n = data_bus_bit_three;
      for (int i = 0; i < PLANES; i++) begin
         s_next.buf_b_n[i] = ~(~read_direction_strobe_n & s_reg.sel[i]);
      end

      s_next.dot  = s_reg.dot + 4'h1;
      s_next.load = (s_reg.dot == LOAD_PHASE - 4'h1);

      s_next.rgb = serial & {PLANES{~blank}};

      s_next.hs_n = ~(ctl_hsync ^ hsync_invert);
      s_next.vs_n = ~(ctl_vsync ^ vsync_invert);
   end

   ////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg         <= '0;
         s_reg.ctl_clk <= 1'b1;
         s_reg.row_n   <= 1'b1;
         s_reg.col_n   <= 1'b1;
         s_reg.d1      <= 1'b1;
         s_reg.d2      <= 1'b1;
         s_reg.d3      <= 1'b1;
         s_reg.we_n    <= 1'b1;
         s_reg.sel     <= PLANE_SEL_RESET;
         s_reg.buf_a_n <= 1'b1;
         s_reg.buf_b_n <= 3'h7;
         s_reg.hs_n    <= 1'b1;
         s_reg.vs_n    <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   assign io_rdata             = s_reg.rdata;
   assign io_rdata_valid       = s_reg.rvalid;
   assign ctl_select           = s_reg.csel;
   assign controller_clock     = s_reg.ctl_clk;
   assign row_strobe_n         = s_reg.row_n;
   assign column_strobe_n      = s_reg.col_n;
   assign mux_select           = s_reg.mux;
   assign address_latch_strobe = s_reg.als;
   assign plane_we_n           = s_reg.we_n;
   // low three bits drive the bus selects
   assign plane_sel            = s_reg.sel[2:0];
   assign buffer_enable_a_n    = s_reg.buf_a_n;
   assign buffer_enable_b_n    = s_reg.buf_b_n;
   assign shift_load           = s_reg.load;
   assign red                  = s_reg.rgb[BIT_RED];
   assign green                = s_reg.rgb[BIT_GREEN];
   assign blue                 = s_reg.rgb[BIT_BLUE];
   assign hsync_n              = s_reg.hs_n;
   assign vsync_n              = s_reg.vs_n;

   ////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_ctl_rise;
      $rose(controller_clock);
   endsequence

   property p_ctl_period;
      s_ctl_rise |=> !$rose(controller_clock) [*7] ##1 s_ctl_rise;
   endproperty
   a_ctl_period: assert property (p_ctl_period) else $error("controller clock not dot/8");

   property p_ctl_duty;
      s_ctl_rise |-> controller_clock [*4] ##1 !controller_clock [*4];
   endproperty
   a_ctl_duty: assert property (p_ctl_duty) else $error("controller clock duty wrong");

   property p_row_phase;
      $changed(row_strobe_n) |-> (s_reg.div == PH_ROW + 3'h1) && $past(controller_clock, 2);
   endproperty
   a_row_phase: assert property (p_row_phase) else $error("row strobe off quarter phase");

   sequence s_row_fall;
      $fell(row_strobe_n);
   endsequence

   property p_col_after_row;
      s_row_fall |-> ##2 $fell(column_strobe_n);
   endproperty
   a_col_after_row: assert property (p_col_after_row) else $error("column strobe not a quarter later");

   property p_mux_between;
      $rose(mux_select) |-> !row_strobe_n && column_strobe_n ##1 $fell(column_strobe_n);
   endproperty
   a_mux_between: assert property (p_mux_between) else $error("mux select out of order");

   property p_we_cause;
      $fell(plane_we_n) |-> $past(s_reg.d2) && !$past(s_reg.d3) && $past(s_reg.div) == PH_ROW;
   endproperty
   a_we_cause: assert property (p_we_cause) else $error("write strobe without delayed trail");

   property p_we_width;
      $fell(plane_we_n) |-> !plane_we_n [*8] ##1 plane_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe not one controller clock");

   property p_buf_sel;
      !buffer_enable_b_n[BIT_RED] |-> $past(s_reg.sel[BIT_RED]) && !$past(read_direction_strobe_n);
   endproperty
   a_buf_sel: assert property (p_buf_sel) else $error("red buffer opened unselected");

   property p_load_period;
      shift_load |-> ##16 shift_load;
   endproperty
   a_load_period: assert property (p_load_period) else $error("load pulse not every 16 dots");

   property p_blank_mask;
      $past(blank) |-> !red && !green && !blue;
   endproperty
   a_blank_mask: assert property (p_blank_mask) else $error("color during blanking");

   property p_sync_pol;
      $past(ctl_hsync) && !$past(hsync_invert) |-> !hsync_n;
   endproperty
   a_sync_pol: assert property (p_sync_pol) else $error("hsync not active low");

   property p_sel_write;
      io_wr && io_addr == PLANE_SEL_ADDR |=> plane_sel == $past(io_wdata[2:0]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("plane select write lost");

   property p_board_id;
      io_rd && io_addr == BOARD_ID_ADDR |=> io_rdata_valid && io_rdata == BOARD_ID;
   endproperty
   a_board_id: assert property (p_board_id) else $error("board id not returned");

   property p_decode;
      (io_rd || io_wr) && io_addr == CTL_HI_A_LAST |=> ctl_select;
   endproperty
   a_decode: assert property (p_decode) else $error("controller port not decoded");

endmodule

// ---- tb/plane_controller_model.sv ----
// Behavioural display controller and plane memory feeding the glue logic
`timescale 1ns/1ps
module plane_controller_model
   import video_glue_pkg::*;
(
   input  wire logic                    ref_clk,                 // Dot clock
   input  wire logic                    rstn,                    // Async reset, active low
   input  wire logic [31:0]             rnd,                     // Random source from bench
   output logic                         ctl_row_strobe_n,        // Row strobe request
   output logic                         read_direction_strobe_n, // Read strobe
   output logic                         data_bus_bit_three,      // Bus bit 3
   output logic                         blank,                   // Blanking, high active
   output logic                         ctl_hsync,               // Horizontal sync
   output logic                         ctl_vsync,               // Vertical sync
   output logic [PLANES*WORD_BITS-1:0]  plane_words              // Blue, green, red words
);
   logic [3:0] dot_reg;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dot_reg                 <= 4'h0;
         ctl_row_strobe_n        <= 1'b1;
         read_direction_strobe_n <= 1'b1;
         data_bus_bit_three      <= 1'b1;
         blank                   <= 1'b1;
         ctl_hsync               <= 1'b0;
         ctl_vsync               <= 1'b0;
         plane_words             <= '0;
      end else begin
         dot_reg <= dot_reg + 4'h1;
         // Strobes move only at controller clock rate, as the real controller does
         if (dot_reg[2:0] == 3'h0) begin
            ctl_row_strobe_n        <= rnd[0];
            read_direction_strobe_n <= rnd[1] | rnd[2];
            data_bus_bit_three      <= rnd[3];
         end
         if (dot_reg == 4'hF) begin
            plane_words <= {rnd[15:0], rnd[31:16], rnd[23:8]};
            blank       <= rnd[4] & rnd[5];
            ctl_hsync   <= rnd[6];
            ctl_vsync   <= rnd[7];
         end
      end
   end
endmodule

// ---- tb/color_video_plane_glue_tb.sv ----
// Self-checking bench comparing the glue logic with a cycle model
`timescale 1ns/1ps
module color_video_plane_glue_tb
   import video_glue_pkg::*;
;
   localparam logic [7:0] ID_VAL = 8'hA7; // Arbitrary identification value
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  io_addr = 8'h00;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic [7:0]  io_wdata = 8'h00;
   logic        hsync_invert = 1'b0;
   logic        vsync_invert = 1'b0;
   logic [31:0] rnd = 32'hFE60;
   logic        row_in_n, rds_n, bit3, blank, hs_in, vs_in;
   logic [47:0] words;
   logic [7:0]  io_rdata;
   logic        io_rdata_valid, ctl_select, controller_clock, row_strobe_n, column_strobe_n;
   logic        mux_select, address_latch_strobe, plane_we_n, buffer_enable_a_n, shift_load;
   logic        red, green, blue, hsync_n, vsync_n;
   logic [2:0]  plane_sel, buffer_enable_b_n;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          cnt_reg, ph, nx;
   logic [7:0]  sel_reg, rdata_reg;
   logic        val_reg, cs_reg, row_reg, col_reg, mux_reg, als_reg, we_reg, bufa_reg, load_reg;
   logic        hs_reg, vs_reg;
   logic [2:0]  d_reg, bufb_reg, rgb_reg;
   logic [15:0] sh_reg [3];
   logic [7:0]  addr_tab [8];
   logic [7:0]  sel_tab [4];

   always #2 ref_clk = ~ref_clk;

   color_video_plane_glue #(.BOARD_ID(ID_VAL)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
      .ctl_select(ctl_select), .controller_clock(controller_clock), .ctl_row_strobe_n(row_in_n),
      .read_direction_strobe_n(rds_n), .data_bus_bit_three(bit3), .blank(blank),
      .ctl_hsync(hs_in), .ctl_vsync(vs_in), .hsync_invert(hsync_invert), .vsync_invert(vsync_invert),
      .plane_words(words), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
      .mux_select(mux_select), .address_latch_strobe(address_latch_strobe), .plane_we_n(plane_we_n),
      .plane_sel(plane_sel), .buffer_enable_a_n(buffer_enable_a_n), .buffer_enable_b_n(buffer_enable_b_n),
      .shift_load(shift_load), .red(red), .green(green), .blue(blue), .hsync_n(hsync_n), .vsync_n(vsync_n));

   plane_controller_model partner (
      .ref_clk(ref_clk), .rstn(rstn), .rnd(rnd), .ctl_row_strobe_n(row_in_n),
      .read_direction_strobe_n(rds_n), .data_bus_bit_three(bit3), .blank(blank),
      .ctl_hsync(hs_in), .ctl_vsync(vs_in), .plane_words(words));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task complete_run;
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One CPU cycle; strobe stays up so calls may follow back to back
   task io_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d);
      io_wr    <= wr;
      io_rd    <= ~wr;
      io_addr  <= a;
      io_wdata <= d;
      @(posedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      rnd <= xorshift(rnd);
      cycles++;
      if (cycles >= 12000) begin
         failures++;
         complete_run();
      end
   end

   // Reference model, reads inputs before this edge's updates land
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 0; sel_reg <= 8'h00; rdata_reg <= 8'h00; val_reg <= 1'b0; cs_reg <= 1'b0;
         row_reg <= 1'b1; col_reg <= 1'b1; mux_reg <= 1'b0; als_reg <= 1'b0; we_reg <= 1'b1;
         d_reg <= 3'h7; bufa_reg <= 1'b1; bufb_reg <= 3'h7; load_reg <= 1'b0; rgb_reg <= 3'h0;
         hs_reg <= 1'b1; vs_reg <= 1'b1;
         for (int i = 0; i < 3; i++) sh_reg[i] <= 16'h0000;
      end else begin
         ph = cnt_reg % 8;
         nx = cnt_reg + 1;
         cnt_reg <= nx;
         if (ph == 1) row_reg <= row_in_n;
         if (ph == 2) mux_reg <= ~row_reg;
         if (ph == 3) col_reg <= row_reg;
         als_reg <= (nx % 8) <= 1;
         if (ph == 7) d_reg <= {d_reg[1:0], rds_n};
         if (ph == 1) we_reg <= ~(d_reg[1] & ~d_reg[2]);
         bufa_reg <= bit3;
         for (int i = 0; i < 3; i++) bufb_reg[i] <= ~(~rds_n & sel_reg[i]);
         load_reg <= (nx % 16) == 15;
         for (int i = 0; i < 3; i++) begin
            sh_reg[i]  <= load_reg ? words[16*i +: 16] : (sh_reg[i] << 1);
            rgb_reg[i] <= sh_reg[i][15] & ~blank;
         end
         hs_reg <= ~(hs_in ^ hsync_invert);
         vs_reg <= ~(vs_in ^ vsync_invert);
         val_reg <= io_rd && (io_addr == BOARD_ID_ADDR || io_addr == PLANE_SEL_ADDR);
         rdata_reg <= !io_rd ? 8'h00 : io_addr == BOARD_ID_ADDR ? ID_VAL :
                      io_addr == PLANE_SEL_ADDR ? sel_reg : 8'h00;
         cs_reg <= (io_rd || io_wr) && ((io_addr >= CTL_LO_A_FIRST && io_addr <= CTL_LO_A_LAST) ||
                                        (io_addr >= CTL_HI_A_FIRST && io_addr <= CTL_HI_A_LAST));
         if (io_wr && io_addr == PLANE_SEL_ADDR) sel_reg <= io_wdata;
      end
   end

   always @(negedge ref_clk) begin
      check("controller_clock", controller_clock, (cnt_reg % 8) < 4);
      check("row_strobe_n", row_strobe_n, row_reg);
      check("column_strobe_n", column_strobe_n, col_reg);
      check("mux_select", mux_select, mux_reg);
      check("address_latch_strobe", address_latch_strobe, als_reg);
      check("plane_we_n", plane_we_n, we_reg);
      check("plane_sel", plane_sel, sel_reg[2:0]);
      check("buffer_enable_a_n", buffer_enable_a_n, bufa_reg);
      check("buffer_enable_b_n", buffer_enable_b_n, bufb_reg);
      check("shift_load", shift_load, load_reg);
      check("rgb", {red, green, blue}, {rgb_reg[2], rgb_reg[1], rgb_reg[0]});
      check("hsync_n", hsync_n, hs_reg);
      check("vsync_n", vsync_n, vs_reg);
      check("io_rdata", io_rdata, rdata_reg);
      check("io_rdata_valid", io_rdata_valid, val_reg);
      check("ctl_select", ctl_select, cs_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      addr_tab = '{8'h2C, 8'h2D, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h2E, 8'h37};
      sel_tab  = '{8'h00, 8'h01, 8'h02, 8'h04};
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      io_cycle(1'b0, PLANE_SEL_ADDR, 8'h00);
      // Each plane code, then read back and identify, back to back
      foreach (sel_tab[i]) begin
         io_cycle(1'b1, PLANE_SEL_ADDR, sel_tab[i]);
         io_cycle(1'b0, PLANE_SEL_ADDR, 8'h00);
         io_cycle(1'b0, BOARD_ID_ADDR, 8'h00);
      end
      // Decode sweep over and around the mapped ports
      for (int a = 8'h28; a <= 8'h3F; a++) io_cycle(1'b0, a[7:0], 8'h00);
      for (int pass = 0; pass < 2; pass++) begin
         for (int n = 0; n < 2500; n++) begin
            io_cycle(rnd[20], rnd[22] ? addr_tab[rnd[2:0]] : rnd[15:8], sel_tab[rnd[9:8]]);
         end
         io_wr <= 1'b0;
         io_rd <= 1'b0;
         @(posedge ref_clk);
         rstn         <= 1'b0;
         hsync_invert <= 1'b1;
         vsync_invert <= 1'b1;
         repeat (2) @(posedge ref_clk);
         rstn <= 1'b1;
         @(posedge ref_clk);
      end
      complete_run();
   end
endmodule
